/* File: pkg/dpram_map.vh */
// Constants for the synchronous dual-port RAM port logic.
// Assumes one system clock drives both ports at 125 MHz.
// Function
// - Shared 32K by 9 storage, both ports
// - Output register select high means pipelined
// - Inputs registered; drive and mode also pass the synchronisers
// - Deselect floats outputs five edges later, six pipelined
// - Strobe low loads external address each edge
// - Output state follows previous cycle controls
// - Strobe and advance high hold address
// - Cross-port read valid after write delay
// - Advance low increments address regardless selects
// - Clear low zeroes address, highest priority
// - Pipelined read data one cycle later
// - Pipelined needs two selected cycles reactivation
`ifndef DPRAM_MAP_VH
`define DPRAM_MAP_VH
`define ADDR_W 15
`define DATA_W 9
`define WORDS 32768
`define ADDR_ZERO 15'h0000
`define DATA_ZERO 9'h000
`define CLK_PERIOD_NS 8
`define WRITE_TO_READ_NS 28
`define WRITE_TO_READ_CYC ((`WRITE_TO_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: design/dpram_array.v */
// Two-port storage array with registered read data.
// Assumes one clock; a same-address read sees the old word.
`timescale 1ns/1ns
`include "dpram_map.vh"
module dpram_array (
    input wire sys_clk,
    input wire a_we,
    input wire [`ADDR_W-1:0] a_addr,
    input wire [`DATA_W-1:0] a_wdata,
    output reg [`DATA_W-1:0] a_rdata,
    input wire b_we,
    input wire [`ADDR_W-1:0] b_addr,
    input wire [`DATA_W-1:0] b_wdata,
    output reg [`DATA_W-1:0] b_rdata
);
    reg [`DATA_W-1:0] mem [0:`WORDS-1];

    // One process owns the array; port B wins a same-address clash
    always @(posedge sys_clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule

/* File: design/dpram_ports.v */
// Dual-port synchronous RAM: two identical ports on a shared array.
// Assumes all port pins arrive asynchronously and pass two flip-flops.
`timescale 1ns/1ns
`include "dpram_map.vh"
module dpram_ports (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] select_active_low,
    input wire [1:0] select_active_high,
    input wire [1:0] write_not_read,
    input wire [1:0] output_drive_enable_n,
    input wire [1:0] output_register_select,
    input wire [1:0] address_load_strobe,
    input wire [1:0] counter_advance_enable,
    input wire [1:0] counter_clear,
    input wire [2*`ADDR_W-1:0] ext_addr,
    input wire [2*`DATA_W-1:0] data_in,
    output reg [2*`DATA_W-1:0] data_out,
    output reg [1:0] data_oe
);
    // =========================================
    // Input synchronisers
    // =========================================
    localparam CW = 8;
    wire [CW-1:0] ctl_pin_a;
    wire [CW-1:0] ctl_pin_b;
    reg [CW-1:0] ctl_s1_a;
    reg [CW-1:0] ctl_s1_b;
    reg [CW-1:0] ctl_a;
    reg [CW-1:0] ctl_b;
    reg [2*`ADDR_W-1:0] addr_s1;
    reg [2*`ADDR_W-1:0] addr_s2;
    reg [2*`DATA_W-1:0] din_s1;
    reg [2*`DATA_W-1:0] din_s2;

    assign ctl_pin_a = {select_active_low[0], select_active_high[0], write_not_read[0],
                        output_drive_enable_n[0], output_register_select[0],
                        address_load_strobe[0], counter_advance_enable[0], counter_clear[0]};
    assign ctl_pin_b = {select_active_low[1], select_active_high[1], write_not_read[1],
                        output_drive_enable_n[1], output_register_select[1],
                        address_load_strobe[1], counter_advance_enable[1], counter_clear[1]};

    // Idle: deselected, read, outputs off, counter held
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_s1_a <= 8'hB7;
            ctl_s1_b <= 8'hB7;
            ctl_a <= 8'hB7;
            ctl_b <= 8'hB7;
            addr_s1 <= 30'h00000000;
            addr_s2 <= 30'h00000000;
            din_s1 <= 18'h00000;
            din_s2 <= 18'h00000;
        end else begin
            ctl_s1_a <= ctl_pin_a;
            ctl_s1_b <= ctl_pin_b;
            ctl_a <= ctl_s1_a;
            ctl_b <= ctl_s1_b;
            addr_s1 <= ext_addr;
            addr_s2 <= addr_s1;
            din_s1 <= data_in;
            din_s2 <= din_s1;
        end
    end

    // =========================================
    // Per-port decode
    // =========================================
    function sel_on;
        input [CW-1:0] c;
        begin
            sel_on = ~c[7] & c[6];
        end
    endfunction

    function [`ADDR_W-1:0] next_address;
        input [CW-1:0] c;
        input [`ADDR_W-1:0] cur;
        input [`ADDR_W-1:0] ext;
        begin
            if (!c[0]) begin
                next_address = `ADDR_ZERO;
            end else if (!c[2]) begin
                next_address = ext;
            end else if (!c[1]) begin
                next_address = cur + 15'h0001;
            end else begin
                next_address = cur;
            end
        end
    endfunction

    wire [CW-1:0] ctl [0:1];
    assign ctl[0] = ctl_a;
    assign ctl[1] = ctl_b;

    // =========================================
    // Registered port stage
    // =========================================
    reg [`ADDR_W-1:0] int_addr [0:1];
    reg [`DATA_W-1:0] wdata_r [0:1];
    reg [1:0] we_r;
    reg [1:0] rd_r;
    reg [1:0] rd_r2;
    reg [1:0] sel_r;
    reg [1:0] sel_r2;
    reg [1:0] sel_r3;
    wire [`DATA_W-1:0] rdata [0:1];
    reg [`DATA_W-1:0] pipe_data [0:1];

    integer i;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < 2; i = i + 1) begin
                int_addr[i] <= `ADDR_ZERO;
                wdata_r[i] <= `DATA_ZERO;
                pipe_data[i] <= `DATA_ZERO;
            end
            we_r <= 2'h0;
            rd_r <= 2'h0;
            rd_r2 <= 2'h0;
            sel_r <= 2'h0;
            sel_r2 <= 2'h0;
            sel_r3 <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                // Address feeds the array in the same cycle it is updated
                int_addr[i] <= next_address(ctl[i], int_addr[i], addr_s2[i*`ADDR_W +: `ADDR_W]);
                wdata_r[i] <= din_s2[i*`DATA_W +: `DATA_W];
                we_r[i] <= sel_on(ctl[i]) & ~ctl[i][5];
                rd_r[i] <= sel_on(ctl[i]) & ctl[i][5];
                sel_r[i] <= sel_on(ctl[i]);
                pipe_data[i] <= rdata[i];
            end
            rd_r2 <= rd_r;
            sel_r2 <= sel_r;
            sel_r3 <= sel_r2;
        end
    end

    // Array access lands one edge after the controls are registered
    dpram_array u_array (
        .sys_clk(sys_clk),
        .a_we(we_r[0]),
        .a_addr(int_addr[0]),
        .a_wdata(wdata_r[0]),
        .a_rdata(rdata[0]),
        .b_we(we_r[1]),
        .b_addr(int_addr[1]),
        .b_wdata(wdata_r[1]),
        .b_rdata(rdata[1])
    );

    // =========================================
    // Output stage
    // =========================================
    // Read data is a cycle behind rd_r; track read-valid alongside
    reg [1:0] flow_valid;
    reg [1:0] pipe_valid;
    reg [1:0] next_oe;
    reg [2*`DATA_W-1:0] next_dout;
    integer k;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flow_valid <= 2'h0;
            pipe_valid <= 2'h0;
        end else begin
            flow_valid <= rd_r;
            // Read cycle and the cycle before it both selected
            pipe_valid <= rd_r2 & sel_r3;
        end
    end

    always @* begin
        next_oe = 2'h0;
        next_dout = data_out;
        for (k = 0; k < 2; k = k + 1) begin
            if (ctl[k][3]) begin
                // Pipelined path
                if (pipe_valid[k]) begin
                    next_dout[k*`DATA_W +: `DATA_W] = pipe_data[k];
                end
                next_oe[k] = pipe_valid[k] & ~ctl[k][4];
            end else begin
                if (flow_valid[k]) begin
                    next_dout[k*`DATA_W +: `DATA_W] = rdata[k];
                end
                next_oe[k] = flow_valid[k] & ~ctl[k][4];
            end
        end
    end

    // Cross-port: a same-cycle read sees the old word; the write shows on the next read
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_out <= 18'h00000;
            data_oe <= 2'h0;
        end else begin
            data_out <= next_dout;
            data_oe <= next_oe;
        end
    end
endmodule

/* File: verif/dpram_checker.sv */
// Pin assertions for port A of the dual-port RAM.
// Assumes reads show five cycles later flow-through, six pipelined; drive enable three.
`timescale 1ns/1ns
module dpram_checker (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] select_active_low,
    input wire [1:0] select_active_high,
    input wire [1:0] write_not_read,
    input wire [1:0] output_drive_enable_n,
    input wire [1:0] output_register_select,
    input wire [1:0] address_load_strobe,
    input wire [1:0] counter_advance_enable,
    input wire [1:0] counter_clear,
    input wire [29:0] ext_addr,
    input wire [17:0] data_in,
    input wire [17:0] data_out,
    input wire [1:0] data_oe
);
    wire sel = !select_active_low[0] && select_active_high[0];
    wire rd = sel && write_not_read[0];
    wire oen = output_drive_enable_n[0];
    wire pl = output_register_select[0];
    wire hold = address_load_strobe[0] && counter_advance_enable[0] && counter_clear[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_desel_flow: assert property ((!sel) ##2 (!pl) |-> ##3 !data_oe[0])
        else $error("driven after deselect");
    a_desel_pipe: assert property ((!sel) ##3 pl |-> ##3 !data_oe[0])
        else $error("driven after deselect");
    a_read_flow: assert property (rd ##2 (!pl && !oen) |-> ##3 data_oe[0])
        else $error("flow read not driven");
    a_read_pipe: assert property ((rd && $past(sel)) ##3 (pl && !oen) |-> ##3 data_oe[0])
        else $error("pipelined read not driven");
    a_reactivate_wait: assert property ((rd && !$past(sel)) ##3 pl |-> ##3 !data_oe[0])
        else $error("driven too soon");
    a_write_quiet: assert property ((sel && !write_not_read[0]) ##2 (!pl) |-> ##3 !data_oe[0])
        else $error("driven on write");
    a_drive_off: assert property (oen |-> ##3 !data_oe[0])
        else $error("driven while disabled");
    a_hold_output: assert property (rd && hold && !pl && $past(rd) |-> ##5 $stable(data_out[8:0]))
        else $error("held data changed");
endmodule
bind dpram_ports dpram_checker i_dpram_checker (.sys_clk, .rst, .select_active_low, .select_active_high,
    .write_not_read, .output_drive_enable_n, .output_register_select, .address_load_strobe,
    .counter_advance_enable, .counter_clear, .ext_addr, .data_in, .data_out, .data_oe);

/* File: verif/ram_host.sv */
// Controller model driving the pins of both RAM ports.
// Assumes one call of op per clock; code bits sel,wnr,oen,adsn,advn,clrn.
`timescale 1ns/1ns
module ram_host (
    input wire sys_clk,
    output reg [1:0] csn,
    output reg [1:0] cs,
    output reg [1:0] wnr,
    output reg [1:0] oen,
    output reg [1:0] mode,
    output reg [1:0] adsn,
    output reg [1:0] advn,
    output reg [1:0] clrn,
    output reg [29:0] addr,
    output reg [17:0] din
);
    initial begin
        {csn, cs, wnr, oen, mode, adsn, advn, clrn} = 16'hCF3F;
        addr = 30'h0000_0000;
        din = 18'h0_0000;
    end
    task op(input integer p, input [5:0] c, input [14:0] a, input [8:0] d);
        begin
            @(posedge sys_clk) #1;
            {cs[p], wnr[p], oen[p], adsn[p], advn[p], clrn[p]} = c;
            csn[p] = !c[5];
            addr[p*15+:15] = a;
            din[p*9+:9] = d;
        end
    endtask
endmodule

/* File: verif/dpram_ports_tb.sv */
// Self-checking bench for the dual-port RAM ports.
// Assumes the host model drives pins one clock per op.
`timescale 1ns/1ns
module dpram_ports_tb;
    reg sys_clk;
    reg rst;
    wire [1:0] csn, cs, wnr, oen, md, adsn, advn, clrn, oe;
    wire [29:0] a;
    wire [17:0] di, q;
    integer failures, compares;
    ram_host i_ram_host (.sys_clk(sys_clk), .csn(csn), .cs(cs), .wnr(wnr), .oen(oen), .mode(md),
        .adsn(adsn), .advn(advn), .clrn(clrn), .addr(a), .din(di));
    dpram_ports i_dpram_ports (.sys_clk(sys_clk), .rst(rst), .select_active_low(csn), .select_active_high(cs),
        .write_not_read(wnr), .output_drive_enable_n(oen), .output_register_select(md),
        .address_load_strobe(adsn), .counter_advance_enable(advn), .counter_clear(clrn),
        .ext_addr(a), .data_in(di), .data_out(q), .data_oe(oe));
    task chk(input [8:0] got, input [8:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd(input integer p, input integer n, input [8:0] e);
        begin
            repeat (n) @(posedge sys_clk);
            #2;
            chk({8'h00, oe[p]}, 9'h001);
            chk(q[p*9+:9], e);
        end
    endtask
    task rw_flow;
        begin
            i_ram_host.op(0, 6'h23, 15'h7FFF, 9'h1A5);
            i_ram_host.op(0, 6'h23, 15'h0123, 9'h05A);
            i_ram_host.op(0, 6'h03, 15'h7FFF, 9'h0FF);
            i_ram_host.op(0, 6'h33, 15'h7FFF, 9'h000);
            i_ram_host.op(0, 6'h33, 15'h0123, 9'h000);
            i_ram_host.op(0, 6'h17, 15'h0000, 9'h000);
            rd(0, 3, 9'h1A5);
            rd(0, 1, 9'h05A);
        end
    endtask
    task cross_port;
        begin
            i_ram_host.op(0, 6'h23, 15'h0040, 9'h133);
            i_ram_host.op(1, 6'h33, 15'h0040, 9'h000);
            i_ram_host.op(0, 6'h17, 15'h0000, 9'h000);
            i_ram_host.op(1, 6'h17, 15'h0000, 9'h000);
            rd(1, 4, 9'h133);
        end
    endtask
    task counter;
        begin
            i_ram_host.op(0, 6'h22, 15'h0155, 9'h0C3);
            i_ram_host.op(0, 6'h25, 15'h0155, 9'h13C);
            i_ram_host.op(0, 6'h32, 15'h0155, 9'h000);
            i_ram_host.op(0, 6'h35, 15'h0155, 9'h000);
            i_ram_host.op(0, 6'h37, 15'h0155, 9'h000);
            i_ram_host.op(0, 6'h17, 15'h0000, 9'h000);
            rd(0, 2, 9'h0C3);
            rd(0, 1, 9'h13C);
            rd(0, 1, 9'h13C);
        end
    endtask
    task pipe;
        begin
            @(posedge sys_clk) #1 i_ram_host.mode[0] = 1'b1;
            repeat (8) @(posedge sys_clk);
            i_ram_host.op(0, 6'h33, 15'h7FFF, 9'h000);
            i_ram_host.op(0, 6'h33, 15'h7FFF, 9'h000);
            i_ram_host.op(0, 6'h17, 15'h0000, 9'h000);
            repeat (4) @(posedge sys_clk);
            #2;
            chk({8'h00, oe[0]}, 9'h000);
            rd(0, 1, 9'h1A5);
        end
    endtask
    task results;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        failures = 0;
        compares = 0;
        rst = 1'b1;
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        rw_flow;
        cross_port;
        counter;
        pipe;
        results;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        failures = failures + 1;
        results;
    end
endmodule
